// [logic/asp_pkg.sv]
// constants shared by the async serial port register block
package asp_pkg;
  localparam int AW = 4;
  localparam int DW = 8;
  // register offsets
  localparam logic [3:0] OFF_DATA  = 4'h0;
  localparam logic [3:0] OFF_IER   = 4'h1;
  localparam logic [3:0] OFF_ISR   = 4'h2;
  localparam logic [3:0] OFF_LCR   = 4'h3;
  localparam logic [3:0] OFF_MCR   = 4'h4;
  localparam logic [3:0] OFF_LSR   = 4'h5;
  localparam logic [3:0] OFF_MSR   = 4'h6;
  localparam logic [3:0] OFF_SCR   = 4'h7;
  localparam logic [3:0] OFF_EVT   = 4'h8;
  localparam logic [3:0] OFF_EMASK = 4'h9;
  // line control fields
  localparam int LCR_DLAB = 7;
  localparam int LCR_SIL  = 6;
  localparam int LCR_FIXP = 5;
  localparam int LCR_EPS  = 4;
  localparam int LCR_PEN  = 3;
  localparam int LCR_STB  = 2;
  // interrupt enable fields
  localparam int IER_RX  = 0;
  localparam int IER_TX  = 1;
  localparam int IER_LS  = 2;
  localparam int IER_MS  = 3;
  // fifo control fields
  localparam int FCR_EN    = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG  = 6;
  // modem control fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  // reset values
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0]  LCR_RST = 8'h03;
  localparam logic [7:0]  ZERO8   = 8'h00;
  // interrupt identity codes, bit 0 low means pending
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LINE = 4'h6;
  localparam logic [3:0] IID_RXD  = 4'h4;
  localparam logic [3:0] IID_TMO  = 4'hC;
  localparam logic [3:0] IID_THR  = 4'h2;
  localparam logic [3:0] IID_MSR  = 4'h0;
  // fifo shape: 8 data bits plus parity, framing, break flags
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_CW    = 5;
  localparam int RX_W       = 11;
  // 16x oversampling tick counts
  localparam logic [4:0] TK_LAST  = 5'h0F;
  localparam logic [4:0] TK_MID   = 5'h07;
  localparam logic [4:0] TK_STOP15 = 5'h17;
  localparam logic [4:0] TK_STOP2 = 5'h1F;
  // receive timeout: four 10-bit characters of 16 ticks
  localparam logic [9:0] TMO_TICKS = 10'h280;
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
endpackage

// [logic/asp_fifo.sv]
// W-bit fifo with count, used for both serial directions
`timescale 1ns/1ps
module asp_fifo
  import asp_pkg::*;
#(
  parameter int W = RX_W
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                clr_i,
  input  wire logic                push_i,
  input  wire logic                pop_i,
  input  wire logic [W-1:0]        din_i,
  output logic      [W-1:0]        dout_o,
  output logic      [FIFO_CW-1:0]  count_o,
  output logic                     empty_o,
  output logic                     full_o
);
  logic [W-1:0]         mem [FIFO_DEPTH];
  logic [FIFO_CW-2:0]   wp_ff;
  logic [FIFO_CW-2:0]   rp_ff;
  logic [FIFO_CW-1:0]   cnt_ff;
  wire                  do_push = push_i & ~full_o;
  wire                  do_pop  = pop_i & ~empty_o;

  assign empty_o = (cnt_ff == '0);
  assign full_o  = (cnt_ff == FIFO_CW'(FIFO_DEPTH));
  assign count_o = cnt_ff;
  assign dout_o  = mem[rp_ff];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wp_ff] <= din_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else if (clr_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= wp_ff + (FIFO_CW-1)'(do_push);
      rp_ff  <= rp_ff + (FIFO_CW-1)'(do_pop);
      cnt_ff <= cnt_ff + FIFO_CW'(do_push) - FIFO_CW'(do_pop);
    end
  end
endmodule

// [logic/asp_uart.sv]
// async serial port: register map, baud generator, transmitter, receiver
//
// Contract
// - a character is start, 5-8 data, optional parity, 1/1.5/2 stops
// - 16-bit divisor 1..65535 yields the 16x tick driving transmit
// - receiver samples on the same 16x tick
// - selectable fifo mode with 16-byte receive and transmit fifos
// - divisor access bit set: offsets 0 and 1 hold divisor bytes
// - divisor access clear: offset 0 reads receive, writes transmit
// - offset 1 holds four interrupt enables, upper bits read zero
// - force silence drives the infrared output to 0 while set
// - force silence touches only the infrared output, not the shifter
// - fixed parity sends and checks inverse of even-parity select
// - data go least significant bit first on the line
// - non-fifo mode reads zero in identity bit 3, fifo bits, fifo error
// - length code 00..11 selects 5..8 data bits
// - extra stop control: 1.5 stops for 5 bits, else 2
// - parity sits between last data bit and first stop
// - even select makes ones count even, otherwise odd
`timescale 1ns/1ps
module asp_uart
  import asp_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  output logic               irq_o,
  input  wire logic          serial_rx_i,
  output logic               serial_tx_line_o,
  output logic               infrared_tx_out_o,
  input  wire logic          cts_b_i,
  input  wire logic          dsr_b_i,
  input  wire logic          ri_b_i,
  input  wire logic          dcd_b_i,
  output logic               rts_b_o,
  output logic               dtr_b_o
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_DATA  = 5'b00100,
    S_PAR   = 5'b01000,
    S_STOP  = 5'b10000
  } asp_state_t;

  logic [15:0]   div_ff;
  logic [15:0]   bcnt_ff;
  logic [7:0]    lcr_ff;
  logic [3:0]    ier_ff;
  logic [4:0]    mcr_ff;
  logic [7:0]    scr_ff;
  logic          fen_ff;
  logic [1:0]    trig_ff;
  logic          oe_ff;
  logic          pe_ff;
  logic          fe_ff;
  logic          bi_ff;
  logic [4:0]    errcnt_ff;
  logic          thri_ff;
  logic          thre_d_ff;
  logic [3:0]    msr_d_ff;
  logic [3:0]    mnow_ff;
  logic [3:0]    evt_ff;
  logic [3:0]    emask_ff;
  logic [9:0]    tmo_ff;
  logic [7:0]    rdata_ff;
  logic [1:0]    rx_sync_ff;
  logic [3:0]    m_meta_ff;
  logic [3:0]    m_sync_ff;
  logic          serial_tx_line_ff;
  logic          irout_ff;
  asp_state_t    tx_st_ff;
  asp_state_t    nxt_tx_st;
  asp_state_t    rx_st_ff;
  asp_state_t    nxt_rx_st;
  logic [4:0]    tx_tk_ff;
  logic [4:0]    nxt_tx_tk;
  logic [2:0]    tx_bit_ff;
  logic [2:0]    nxt_tx_bit;
  logic [7:0]    tx_sh_ff;
  logic [7:0]    nxt_tx_sh;
  logic          tx_line_ff;
  logic          nxt_tx_line;
  logic [4:0]    rx_tk_ff;
  logic [4:0]    nxt_rx_tk;
  logic [2:0]    rx_bit_ff;
  logic [2:0]    nxt_rx_bit;
  logic [7:0]    rx_sh_ff;
  logic [7:0]    nxt_rx_sh;
  logic          rx_perr_ff;
  logic          nxt_rx_perr;
  logic          rx_push;
  logic          tx_pop;
  logic          tx_done;
  logic [7:0]    rd_mux;
  logic [3:0]    iid;

  // register decode
  wire dlab     = lcr_ff[LCR_DLAB];
  wire wr_data  = wr_i & (addr_i == OFF_DATA);
  wire wr_ier   = wr_i & (addr_i == OFF_IER);
  wire wr_fcr   = wr_i & (addr_i == OFF_ISR);
  wire rd_data  = rd_i & (addr_i == OFF_DATA);
  wire wr_tbr   = wr_data & ~dlab;
  wire rd_rbr   = rd_data & ~dlab;
  wire wr_dll   = wr_data & dlab;
  wire wr_dlh   = wr_ier & dlab;
  wire rd_isr   = rd_i & (addr_i == OFF_ISR);
  wire rd_lsr   = rd_i & (addr_i == OFF_LSR);
  wire rd_msr   = rd_i & (addr_i == OFF_MSR);
  wire fen_chg  = wr_fcr & (wdata_i[FCR_EN] != fen_ff);
  wire rx_clr   = fen_chg | (wr_fcr & wdata_i[FCR_RXCLR]);
  wire tx_clr   = fen_chg | (wr_fcr & wdata_i[FCR_TXCLR]);
  wire loop     = mcr_ff[MCR_LOOP];

  // frame format
  wire [1:0] len    = lcr_ff[1:0];
  wire [2:0] last_b = {1'b1, len};
  wire [7:0] lmask  = 8'hFF >> (2'h3 - len);
  wire       pen    = lcr_ff[LCR_PEN];
  wire       eps    = lcr_ff[LCR_EPS];
  wire       fixp   = lcr_ff[LCR_FIXP];
  wire [4:0] stop_last = !lcr_ff[LCR_STB] ? TK_LAST :
                         (len == 2'h0) ? TK_STOP15 : TK_STOP2;

  // baud generator; divisor zero stops the tick
  wire tick = (div_ff != '0) && (bcnt_ff >= div_ff - 16'h0001);

  // fifos
  logic [RX_W-1:0]    rx_head;
  logic [FIFO_CW-1:0] rx_cnt;
  logic [FIFO_CW-1:0] tx_cnt;
  logic [7:0]         tx_head;
  logic               rx_empty;
  logic               rx_full;
  logic               tx_empty;
  logic               tx_full;
  wire [RX_W-1:0] rx_entry;
  // without fifo mode each fifo stands in for a one-byte holding register
  wire rx_room  = fen_ff ? ~rx_full : rx_empty;
  wire tx_room  = fen_ff ? ~tx_full : tx_empty;
  wire rx_pop   = rd_rbr & ~rx_empty;
  wire entry_err = |rx_entry[RX_W-1:DW];
  wire head_err  = |rx_head[RX_W-1:DW];

  asp_fifo #(.W(RX_W)) u_rx_fifo (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (rx_clr),
    .push_i  (rx_push & rx_room),
    .pop_i   (rx_pop),
    .din_i   (rx_entry),
    .dout_o  (rx_head),
    .count_o (rx_cnt),
    .empty_o (rx_empty),
    .full_o  (rx_full)
  );

  asp_fifo #(.W(DW)) u_tx_fifo (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (tx_clr),
    .push_i  (wr_tbr & tx_room),
    .pop_i   (tx_pop),
    .din_i   (wdata_i),
    .dout_o  (tx_head),
    .count_o (tx_cnt),
    .empty_o (tx_empty),
    .full_o  (tx_full)
  );

  // transmitter
  wire tx_par = fixp ? ~eps : (eps ? ^(tx_sh_ff & lmask) : ~^(tx_sh_ff & lmask));
  wire tx_idle = (tx_st_ff == S_IDLE);
  assign tx_pop = tx_idle & tick & ~tx_empty;

  always_comb begin
    nxt_tx_st   = tx_st_ff;
    nxt_tx_tk   = tx_tk_ff;
    nxt_tx_bit  = tx_bit_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_line = tx_line_ff;
    tx_done     = 1'b0;
    if (tick) begin
      nxt_tx_tk = tx_tk_ff + 5'h01;
      unique case (tx_st_ff)
        S_IDLE: begin
          nxt_tx_line = 1'b1;
          if (!tx_empty) begin
            nxt_tx_st   = S_START;
            nxt_tx_sh   = tx_head;
            nxt_tx_line = 1'b0;
            nxt_tx_tk   = '0;
          end
        end
        S_START: if (tx_tk_ff == TK_LAST) begin
          nxt_tx_st   = S_DATA;
          nxt_tx_line = tx_sh_ff[0];
          nxt_tx_bit  = '0;
          nxt_tx_tk   = '0;
        end
        S_DATA: if (tx_tk_ff == TK_LAST) begin
          nxt_tx_tk = '0;
          nxt_tx_bit = tx_bit_ff + 3'h1;
          // byte held whole so parity still sees every data bit
          nxt_tx_line = tx_sh_ff[tx_bit_ff + 3'h1];
          if (tx_bit_ff == last_b) begin
            nxt_tx_st   = pen ? S_PAR : S_STOP;
            nxt_tx_line = pen ? tx_par : 1'b1;
          end
        end
        S_PAR: if (tx_tk_ff == TK_LAST) begin
          nxt_tx_st   = S_STOP;
          nxt_tx_line = 1'b1;
          nxt_tx_tk   = '0;
        end
        S_STOP: if (tx_tk_ff == stop_last) begin
          nxt_tx_st = S_IDLE;
          tx_done   = 1'b1;
        end
      endcase
    end
  end

  // receiver; loopback feeds the shifter output straight back
  wire rx_in   = loop ? tx_line_ff : rx_sync_ff[1];
  wire [7:0] rx_byte = rx_sh_ff >> (2'h3 - len);
  wire rx_exp  = fixp ? ~eps : (eps ? ^rx_byte : ~^rx_byte);
  wire rx_brk  = ~rx_in & (rx_sh_ff == '0) & ~rx_perr_ff;
  assign rx_entry = {rx_brk, ~rx_in, rx_perr_ff, rx_byte};

  always_comb begin
    nxt_rx_st   = rx_st_ff;
    nxt_rx_tk   = rx_tk_ff;
    nxt_rx_bit  = rx_bit_ff;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_perr = rx_perr_ff;
    rx_push     = 1'b0;
    if (tick) begin
      nxt_rx_tk = rx_tk_ff + 5'h01;
      unique case (rx_st_ff)
        S_IDLE: if (!rx_in) begin
          nxt_rx_st = S_START;
          nxt_rx_tk = '0;
        end
        S_START: if (rx_tk_ff == TK_MID) begin
          // a glitch shorter than half a bit is not a start
          nxt_rx_st   = rx_in ? S_IDLE : S_DATA;
          nxt_rx_tk   = '0;
          nxt_rx_bit  = '0;
          nxt_rx_perr = 1'b0;
          nxt_rx_sh   = '0;
        end
        S_DATA: if (rx_tk_ff == TK_LAST) begin
          nxt_rx_tk  = '0;
          nxt_rx_sh  = {rx_in, rx_sh_ff[7:1]};
          nxt_rx_bit = rx_bit_ff + 3'h1;
          if (rx_bit_ff == last_b) begin
            nxt_rx_st = pen ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (rx_tk_ff == TK_LAST) begin
          nxt_rx_tk   = '0;
          nxt_rx_perr = (rx_in != rx_exp);
          nxt_rx_st   = S_STOP;
        end
        S_STOP: if (rx_tk_ff == TK_LAST) begin
          // only the first stop is checked; the next start may follow
          rx_push   = 1'b1;
          nxt_rx_st = S_IDLE;
        end
      endcase
    end
  end

  // status
  wire rx_ok    = rx_push & rx_room;
  wire thre     = tx_empty;
  wire temt     = tx_empty & tx_idle;
  wire rfe      = fen_ff & (errcnt_ff != '0);
  wire [7:0] lsr = {rfe, temt, thre, bi_ff, fe_ff, pe_ff, oe_ff, ~rx_empty};
  wire [3:0] mpin  = ~m_sync_ff;
  wire [3:0] mloop = {mcr_ff[MCR_OUT2], mcr_ff[MCR_OUT1], mcr_ff[MCR_DTR], mcr_ff[MCR_RTS]};
  wire [3:0] mcur  = loop ? mloop : mpin;
  wire [3:0] mchg  = {mcur[3] ^ mnow_ff[3], ~mcur[2] & mnow_ff[2],
                      mcur[1] ^ mnow_ff[1], mcur[0] ^ mnow_ff[0]};
  wire [4:0] trig  = (trig_ff == 2'h0) ? TRIG_1 : (trig_ff == 2'h1) ? TRIG_4 :
                     (trig_ff == 2'h2) ? TRIG_8 : TRIG_14;
  wire rx_lvl   = fen_ff ? (rx_cnt >= trig) : ~rx_empty;
  wire tmo_hit  = fen_ff & ~rx_empty & (tmo_ff == TMO_TICKS);
  wire line_err = oe_ff | pe_ff | fe_ff | bi_ff;

  // identity in priority order
  always_comb begin
    if (ier_ff[IER_LS] && line_err) begin
      iid = IID_LINE;
    end else if (ier_ff[IER_RX] && rx_lvl) begin
      iid = IID_RXD;
    end else if (ier_ff[IER_RX] && tmo_hit) begin
      iid = IID_TMO;
    end else if (ier_ff[IER_TX] && thri_ff) begin
      iid = IID_THR;
    end else if (ier_ff[IER_MS] && (msr_d_ff != '0)) begin
      iid = IID_MSR;
    end else begin
      iid = IID_NONE;
    end
  end

  wire [3:0] evt_set = {|mchg, rx_ok & entry_err | rx_push & ~rx_room, tx_done, rx_ok};
  // sticky events gated by their mask join the enabled identity sources
  assign irq_o = (iid != IID_NONE) | |(evt_ff & emask_ff);

  // read mux
  always_comb begin
    unique case (addr_i)
      OFF_DATA:  rd_mux = dlab ? div_ff[7:0] : rx_head[DW-1:0];
      OFF_IER:   rd_mux = dlab ? div_ff[15:8] : {4'h0, ier_ff};
      OFF_ISR:   rd_mux = {{2{fen_ff}}, 2'h0, iid};
      OFF_LCR:   rd_mux = lcr_ff;
      OFF_MCR:   rd_mux = {3'h0, mcr_ff};
      OFF_LSR:   rd_mux = lsr;
      OFF_MSR:   rd_mux = {mcur, msr_d_ff};
      OFF_SCR:   rd_mux = scr_ff;
      OFF_EVT:   rd_mux = {4'h0, evt_ff};
      OFF_EMASK: rd_mux = {4'h0, emask_ff};
      default:   rd_mux = ZERO8;
    endcase
  end

  assign rdata_o           = rdata_ff;
  assign serial_tx_line_o  = serial_tx_line_ff;
  assign infrared_tx_out_o = irout_ff;
  assign rts_b_o           = loop | ~mcr_ff[MCR_RTS];
  assign dtr_b_o           = loop | ~mcr_ff[MCR_DTR];

  // pin synchronisers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sync_ff <= 2'h3;
      m_meta_ff  <= 4'hF;
      m_sync_ff  <= 4'hF;
    end else begin
      rx_sync_ff <= {rx_sync_ff[0], serial_rx_i};
      m_meta_ff  <= {dcd_b_i, ri_b_i, dsr_b_i, cts_b_i};
      m_sync_ff  <= m_meta_ff;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff   <= DIV_RST;
      lcr_ff   <= LCR_RST;
      ier_ff   <= '0;
      mcr_ff   <= '0;
      scr_ff   <= '0;
      fen_ff   <= 1'b0;
      trig_ff  <= '0;
      emask_ff <= '0;
    end else begin
      if (wr_dll) div_ff[7:0] <= wdata_i;
      if (wr_dlh) div_ff[15:8] <= wdata_i;
      if (wr_ier & ~dlab) ier_ff <= wdata_i[3:0];
      if (wr_i && addr_i == OFF_LCR) lcr_ff <= wdata_i;
      if (wr_i && addr_i == OFF_MCR) mcr_ff <= wdata_i[4:0];
      if (wr_i && addr_i == OFF_SCR) scr_ff <= wdata_i;
      if (wr_i && addr_i == OFF_EMASK) emask_ff <= wdata_i[3:0];
      if (wr_fcr) begin
        fen_ff  <= wdata_i[FCR_EN];
        trig_ff <= wdata_i[FCR_TRIG+1:FCR_TRIG];
      end
    end
  end

  // engines, status and bus answer; every sticky flag's hardware set beats its clear, but rx_clr beats the error count's increment
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_ff    <= '0;
      tx_st_ff   <= S_IDLE;
      tx_tk_ff   <= '0;
      tx_bit_ff  <= '0;
      tx_sh_ff   <= '0;
      tx_line_ff <= 1'b1;
      rx_st_ff   <= S_IDLE;
      rx_tk_ff   <= '0;
      rx_bit_ff  <= '0;
      rx_sh_ff   <= '0;
      rx_perr_ff <= 1'b0;
      oe_ff      <= 1'b0;
      pe_ff      <= 1'b0;
      fe_ff      <= 1'b0;
      bi_ff      <= 1'b0;
      errcnt_ff  <= '0;
      thri_ff    <= 1'b0;
      thre_d_ff  <= 1'b1;
      msr_d_ff   <= '0;
      mnow_ff    <= '0;
      evt_ff     <= '0;
      tmo_ff     <= '0;
      rdata_ff   <= '0;
      serial_tx_line_ff    <= 1'b1;
      irout_ff   <= 1'b1;
    end else begin
      bcnt_ff    <= tick ? '0 : bcnt_ff + 16'h0001;
      tx_st_ff   <= nxt_tx_st;
      tx_tk_ff   <= nxt_tx_tk;
      tx_bit_ff  <= nxt_tx_bit;
      tx_sh_ff   <= nxt_tx_sh;
      tx_line_ff <= nxt_tx_line;
      rx_st_ff   <= nxt_rx_st;
      rx_tk_ff   <= nxt_rx_tk;
      rx_bit_ff  <= nxt_rx_bit;
      rx_sh_ff   <= nxt_rx_sh;
      rx_perr_ff <= nxt_rx_perr;
      oe_ff <= (oe_ff & ~rd_lsr) | (rx_push & ~rx_room);
      pe_ff <= (pe_ff & ~rd_lsr) | (rx_ok & rx_entry[DW]);
      fe_ff <= (fe_ff & ~rd_lsr) | (rx_ok & rx_entry[DW+1]);
      bi_ff <= (bi_ff & ~rd_lsr) | (rx_ok & rx_entry[DW+2]);
      errcnt_ff <= rx_clr ? '0 : errcnt_ff + FIFO_CW'(rx_ok & entry_err)
                                           - FIFO_CW'(rx_pop & head_err);
      thre_d_ff <= thre;
      thri_ff <= (thri_ff & ~wr_tbr & ~(rd_isr & iid == IID_THR)) | (thre & ~thre_d_ff);
      mnow_ff  <= mcur;
      msr_d_ff <= (msr_d_ff & {4{~rd_msr}}) | mchg;
      evt_ff <= (evt_ff & ~({4{wr_i && addr_i == OFF_EVT}} & wdata_i[3:0])) | evt_set;
      if (rx_ok | rx_pop | rx_empty) begin
        tmo_ff <= '0;
      end else if (tick && tmo_ff != TMO_TICKS) begin
        tmo_ff <= tmo_ff + 10'h001;
      end
      rdata_ff <= rd_i ? rd_mux : ZERO8;
      serial_tx_line_ff  <= loop | tx_line_ff;
      // silence only gates the infrared copy; the shifter runs on
      irout_ff <= ~lcr_ff[LCR_SIL] & (loop | tx_line_ff);
    end
  end
endmodule

// [verif/asp_uart_assertions.sv]
// checker for the async serial port register block
`timescale 1ns/1ps
module asp_uart_assertions
  import asp_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_b_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          irq_o,
  input wire logic          serial_tx_line_o,
  input wire logic          infrared_tx_out_o
);
  logic [7:0]  lcr_ff;
  logic [7:0]  ier_ff;
  logic [7:0]  msk_ff;
  logic [15:0] div_ff;
  logic        fen_ff;
  wire logic   dl = lcr_ff[LCR_DLAB];
  // shadow of the host writes, so reads can be predicted
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lcr_ff <= LCR_RST;
      ier_ff <= ZERO8;
      msk_ff <= ZERO8;
      div_ff <= DIV_RST;
      fen_ff <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == OFF_LCR) lcr_ff <= wdata_i;
      if (addr_i == OFF_DATA && dl) div_ff[7:0] <= wdata_i;
      if (addr_i == OFF_IER && dl) div_ff[15:8] <= wdata_i;
      if (addr_i == OFF_IER && !dl) ier_ff <= wdata_i;
      if (addr_i == OFF_ISR) fen_ff <= wdata_i[FCR_EN];
      if (addr_i == OFF_EMASK) msk_ff <= wdata_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == ZERO8)
    else $error("read data not idle");
  AST_DIV_LO: assert property (rd_i && addr_i == OFF_DATA && dl |=> rdata_o == div_ff[7:0])
    else $error("divisor low mismatch");
  AST_DIV_HI: assert property (rd_i && addr_i == OFF_IER && dl |=> rdata_o == div_ff[15:8])
    else $error("divisor high mismatch");
  AST_IER: assert property (rd_i && addr_i == OFF_IER && !dl |=> rdata_o == {4'h0, ier_ff[3:0]})
    else $error("enable readback mismatch");
  AST_ISR_FEN: assert property (rd_i && addr_i == OFF_ISR |=> rdata_o[7:4] == {{2{fen_ff}}, 2'b00})
    else $error("identity upper bits wrong");
  AST_ISR_NF: assert property (rd_i && addr_i == OFF_ISR && !fen_ff |=> !rdata_o[3])
    else $error("timeout code without fifo");
  AST_LSR_NF: assert property (rd_i && addr_i == OFF_LSR && !fen_ff |=> !rdata_o[7])
    else $error("fifo error flag without fifo");
  AST_SIL: assert property (lcr_ff[LCR_SIL] && $past(lcr_ff[LCR_SIL]) |-> !infrared_tx_out_o)
    else $error("infrared output not silent");
  AST_IRQ_OFF: assert property (ier_ff[3:0] == 4'h0 && msk_ff == ZERO8 |-> !irq_o)
    else $error("interrupt with all sources off");
  // no bit on the line is shorter than 9 clocks
  AST_BIT_HOLD: assert property ($changed(serial_tx_line_o) |=> $stable(serial_tx_line_o)[*8])
    else $error("serial bit too short");
endmodule
bind asp_uart asp_uart_assertions u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .serial_tx_line_o(serial_tx_line_o),
  .infrared_tx_out_o(infrared_tx_out_o));

// [verif/asp_peer.sv]
// remote serial peer: sends frames and captures frames sent to it
`timescale 1ns/1ps
module asp_peer #(
  parameter int BT = 32
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  initial line_o = 1'b1;
  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BT) @(posedge clk_i);
  endtask
  // start, data lsb first, optional parity, stop
  task automatic send(input logic [7:0] d, input int n, input int p);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (p >= 0) bit_out(p[0]);
    bit_out(1'b1);
  endtask
  // sample mid-bit; only the first stop is looked at
  task automatic take(input int n, input logic pe, output logic [7:0] d,
                      output logic p, output logic s);
    d = 8'h00;
    p = 1'b0;
    @(negedge line_i);
    repeat (BT / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (BT) @(posedge clk_i);
      d[i] = line_i;
    end
    if (pe) begin
      repeat (BT) @(posedge clk_i);
      p = line_i;
    end
    repeat (BT) @(posedge clk_i);
    s = line_i;
  endtask
endmodule

// [verif/asp_uart_tb.sv]
// self-checking bench for the async serial port register block
`timescale 1ns/1ps
module asp_uart_tb;
  import asp_pkg::*;
  localparam int BT = 32;
  logic          clk_i   = 1'b0;
  logic          rst_b_i = 1'b0;
  logic [AW-1:0] addr_i  = '0;
  logic [DW-1:0] wdata_i = '0;
  logic          wr_i    = 1'b0;
  logic          rd_i    = 1'b0;
  logic [DW-1:0] rdata_o;
  logic          irq_o;
  logic          rx_line;
  logic          tx_line;
  logic [1:0]    mdm_b;
  logic [7:0]    d;
  logic          p;
  logic          s;
  int            errors      = 0;
  int            check_count = 0;
  // formats: 8N1, 7E1, 5O1.5, 6 fixed parity 2 stop with silence
  logic [7:0]    fmt [4] = '{8'h03, 8'h1A, 8'h0C, 8'h7D};
  logic [7:0]    dat [4] = '{8'h55, 8'hB3, 8'h1E, 8'hCA};
  always #10 clk_i = ~clk_i;
  asp_uart DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .serial_rx_i(rx_line),
    .serial_tx_line_o(tx_line), .infrared_tx_out_o(), .cts_b_i(1'b1), .dsr_b_i(1'b1),
    .ri_b_i(1'b1), .dcd_b_i(1'b1), .rts_b_o(mdm_b[1]), .dtr_b_o(mdm_b[0]));
  asp_peer #(.BT(BT)) peer (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_line));
  function automatic logic [7:0] msk(input logic [7:0] f);
    return 8'hFF >> (3 - f[1:0]);
  endfunction
  function automatic logic par(input logic [7:0] v, input logic [7:0] f);
    return f[3] & (f[5] ? ~f[4] : ((^(v & msk(f))) ~^ f[4]));
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e);
    @(posedge clk_i);
  endtask
  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a hang is cut short well after the frames should be done
  initial begin
    #400000;
    errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(OFF_LCR, 8'hFF, LCR_RST);
    rd(OFF_ISR, 8'hFF, {4'h0, IID_NONE});
    rd(OFF_LSR, 8'h80, ZERO8);
    rd(4'hF, 8'hFF, ZERO8);
    wr(OFF_MCR, 8'h03);
    chk({6'h0, mdm_b}, 8'h00);
    wr(OFF_MCR, 8'h00);
    chk({6'h0, mdm_b}, 8'h03);
    wr(OFF_SCR, 8'hA5);
    rd(OFF_SCR, 8'hFF, 8'hA5);
    wr(OFF_LCR, 8'h83);
    rd(OFF_DATA, 8'hFF, DIV_RST[7:0]);
    wr(OFF_DATA, 8'h02);
    wr(OFF_IER, 8'h5A);
    rd(OFF_IER, 8'hFF, 8'h5A);
    wr(OFF_IER, 8'h00);
    rd(OFF_DATA, 8'hFF, 8'h02);
    wr(OFF_LCR, 8'h03);
    wr(OFF_IER, 8'hFF);
    rd(OFF_IER, 8'hFF, 8'h0F);
    wr(OFF_IER, 8'h00);
    // divisor 2 gives 32 clocks a bit on both directions
    foreach (fmt[i]) begin
      wr(OFF_LCR, fmt[i]);
      wr(OFF_DATA, dat[i]);
      peer.take(fmt[i][1:0] + 5, fmt[i][3], d, p, s);
      chk(d, dat[i] & msk(fmt[i]));
      chk({7'h0, p}, {7'h0, par(dat[i], fmt[i])});
      chk({7'h0, s}, 8'h01);
      peer.send(dat[i], fmt[i][1:0] + 5, fmt[i][3] ? int'(par(dat[i], fmt[i])) : -1);
      rd(OFF_LSR, 8'h0F, 8'h01);
      rd(OFF_DATA, 8'hFF, dat[i] & msk(fmt[i]));
    end
    wr(OFF_LCR, 8'h1B);
    peer.send(8'h0F, 8, 1);
    rd(OFF_LSR, 8'h0F, 8'h05);
    rd(OFF_DATA, 8'hFF, 8'h0F);
    wr(OFF_LCR, 8'h03);
    wr(OFF_IER, 8'h01);
    peer.send(8'h3C, 8, -1);
    chk({7'h0, irq_o}, 8'h01);
    rd(OFF_DATA, 8'hFF, 8'h3C);
    chk({7'h0, irq_o}, 8'h00);
    wr(OFF_EVT, 8'hFF);
    wr(OFF_EMASK, 8'h02);
    chk({7'h0, irq_o}, 8'h00);
    wr(OFF_DATA, 8'h81);
    peer.take(8, 1'b0, d, p, s);
    chk(d, 8'h81);
    repeat (BT) @(posedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    wr(OFF_EMASK, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    wr(OFF_EMASK, 8'h02);
    chk({7'h0, irq_o}, 8'h01);
    wr(OFF_EVT, 8'h02);
    chk({7'h0, irq_o}, 8'h00);
    // without the fifo the second byte would be dropped
    wr(OFF_ISR, 8'h01);
    rd(OFF_ISR, 8'hC0, 8'hC0);
    peer.send(8'h11, 8, -1);
    peer.send(8'h22, 8, -1);
    rd(OFF_DATA, 8'hFF, 8'h11);
    rd(OFF_DATA, 8'hFF, 8'h22);
    final_report();
  end
endmodule
